// >>> design/srzsd_pkg.sv
// Constants and carrier types for the speed ramp and standstill block
package srzsd_pkg;
    // ------------------------------------------------------------
    // Parameter map addresses
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_ACCEL = 16'h0144;
    localparam logic [15:0] ADDR_DECEL = 16'h0146;
    localparam logic [15:0] ADDR_SCURVE = 16'h0148;
    localparam logic [15:0] ADDR_INERTIA = 16'h014a;
    localparam logic [15:0] ADDR_WINDOW = 16'h014c;
    localparam logic [15:0] ADDR_TARGET = 16'h014e;
    // ------------------------------------------------------------
    // Reset values and ranges
    // ------------------------------------------------------------
    localparam logic [15:0] RST_ACCEL = 16'h00c8;
    localparam logic [15:0] RST_DECEL = 16'h00c8;
    localparam logic [15:0] RST_SCURVE = 16'h0000;
    localparam logic [15:0] RST_INERTIA = 16'h000a;
    localparam logic [15:0] RST_WINDOW = 16'h0064;
    localparam logic [15:0] RST_TARGET = 16'h0bb8;
    localparam logic [15:0] MIN_TIME = 16'h0001;
    localparam logic [15:0] MAX_TIME = 16'hffdc;
    localparam logic [15:0] MAX_INERTIA = 16'h07d0;
    localparam logic [15:0] MAX_WINDOW = 16'h07d0;
    localparam logic [15:0] MAX_TARGET = 16'h1388;
    localparam logic [15:0] ANA_MAX_RAMP = 16'h4e20;
    localparam logic [15:0] ANA_MAX_SCURVE = 16'h2710;
    localparam logic [15:0] SCURVE_COMP_ONLY = 16'h0001;
    localparam logic [15:0] SCURVE_OFF = 16'h0000;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [4:0] TARGET_SCALE = 5'h0a;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
    localparam int RATED_SPEED = 30000;
    // ------------------------------------------------------------
    // Settings carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] accel;
        logic [15:0] decel;
        logic [15:0] scurve;
        logic [15:0] inertia;
        logic [15:0] window;
        logic [15:0] target;
    } srzsd_cfg_s;
endpackage : srzsd_pkg

// >>> design/srzsd_top.sv
// Speed reference ramp with standstill and speed-reached detection
// Behaviour
// - Accel time spans standstill to rated speed
// - Smoothed acceleration lasts accel plus S-curve time
// - Smoothed deceleration lasts decel plus S-curve time
// - Zero S-curve with non-analog source disables smoothing and compensation only
// - S-curve value decodes smoothing and compensation
// - S-curve time 0 to 65500 ms
// - Analog source with zero S-curve bypasses ramp
// - Analog source clamps accel time to 20000
// - Analog source clamps decel time to 20000
// - Analog source clamps S-curve time to 10000
// - Inertia ratio held, range 0 to 2000
// - Standstill flag when speed within window
// - Standstill holds until speed exceeds window
// - Speed reached flag while speed at or above target
`timescale 1ns/1ps
module srzsd_top #(
    parameter int SPW = 24,
    parameter int FRW = 16,
    parameter int TICK_CYCLES = srzsd_pkg::TICK_CYCLES,
    parameter int RATED = srzsd_pkg::RATED_SPEED
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic en,
    input wire logic par_wr,
    input wire logic par_rd,
    input wire logic [15:0] par_addr,
    input wire logic [15:0] par_wdata,
    output logic [15:0] par_rdata_q,
    input wire logic analog_src,
    input wire logic comp_select,
    input wire logic signed [SPW-1:0] speed_cmd,
    input wire logic signed [SPW-1:0] speed_meas,
    output logic signed [SPW-1:0] speed_ref_q,
    output logic scurve_en_q,
    output logic track_comp_q,
    output logic standstill_flag_q,
    output logic speed_reached_flag_q
);
    localparam int W = SPW + FRW;
    localparam logic [W-1:0] RATED_FX = W'(RATED) << FRW;
    // ------------------------------------------------------------
    // Parameter map
    // ------------------------------------------------------------
    srzsd_pkg::srzsd_cfg_s cfg_q;
    wire wr_acc = par_wr && par_addr == srzsd_pkg::ADDR_ACCEL;
    wire wr_dec = par_wr && par_addr == srzsd_pkg::ADDR_DECEL;
    wire wr_scv = par_wr && par_addr == srzsd_pkg::ADDR_SCURVE;
    wire wr_ine = par_wr && par_addr == srzsd_pkg::ADDR_INERTIA;
    wire wr_win = par_wr && par_addr == srzsd_pkg::ADDR_WINDOW;
    wire wr_tgt = par_wr && par_addr == srzsd_pkg::ADDR_TARGET;
    wire [15:0] time_wr = (par_wdata < srzsd_pkg::MIN_TIME) ? srzsd_pkg::MIN_TIME :
        (par_wdata > srzsd_pkg::MAX_TIME) ? srzsd_pkg::MAX_TIME : par_wdata;
    wire [15:0] scv_wr = (par_wdata > srzsd_pkg::MAX_TIME) ? srzsd_pkg::MAX_TIME :
        par_wdata;
    wire [15:0] ine_wr = (par_wdata > srzsd_pkg::MAX_INERTIA) ? srzsd_pkg::MAX_INERTIA :
        par_wdata;
    wire [15:0] win_wr = (par_wdata > srzsd_pkg::MAX_WINDOW) ? srzsd_pkg::MAX_WINDOW :
        par_wdata;
    wire [15:0] tgt_wr = (par_wdata > srzsd_pkg::MAX_TARGET) ? srzsd_pkg::MAX_TARGET :
        par_wdata;
    wire [15:0] rd_mux = (par_addr == srzsd_pkg::ADDR_ACCEL) ? cfg_q.accel :
        (par_addr == srzsd_pkg::ADDR_DECEL) ? cfg_q.decel :
        (par_addr == srzsd_pkg::ADDR_SCURVE) ? cfg_q.scurve :
        (par_addr == srzsd_pkg::ADDR_INERTIA) ? cfg_q.inertia :
        (par_addr == srzsd_pkg::ADDR_WINDOW) ? cfg_q.window :
        (par_addr == srzsd_pkg::ADDR_TARGET) ? cfg_q.target : srzsd_pkg::WORD_ZERO;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg_q <= {srzsd_pkg::RST_ACCEL, srzsd_pkg::RST_DECEL, srzsd_pkg::RST_SCURVE,
                      srzsd_pkg::RST_INERTIA, srzsd_pkg::RST_WINDOW, srzsd_pkg::RST_TARGET};
            par_rdata_q <= srzsd_pkg::WORD_ZERO;
        end else if (en) begin
            if (wr_acc) cfg_q.accel <= time_wr;
            if (wr_dec) cfg_q.decel <= time_wr;
            if (wr_scv) cfg_q.scurve <= scv_wr;
            if (wr_ine) cfg_q.inertia <= ine_wr;
            if (wr_win) cfg_q.window <= win_wr;
            if (wr_tgt) cfg_q.target <= tgt_wr;
            if (par_rd) par_rdata_q <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Effective times and S-curve decode
    // ------------------------------------------------------------
    wire [15:0] acc_eff = (analog_src && cfg_q.accel > srzsd_pkg::ANA_MAX_RAMP) ?
        srzsd_pkg::ANA_MAX_RAMP : cfg_q.accel;
    wire [15:0] dec_eff = (analog_src && cfg_q.decel > srzsd_pkg::ANA_MAX_RAMP) ?
        srzsd_pkg::ANA_MAX_RAMP : cfg_q.decel;
    wire [15:0] scv_eff = (analog_src && cfg_q.scurve > srzsd_pkg::ANA_MAX_SCURVE) ?
        srzsd_pkg::ANA_MAX_SCURVE : cfg_q.scurve;
    wire smooth = scv_eff > srzsd_pkg::SCURVE_COMP_ONLY;
    wire comp = (scv_eff == srzsd_pkg::SCURVE_COMP_ONLY) || (smooth && comp_select);
    wire bypass = analog_src && (cfg_q.scurve == srzsd_pkg::SCURVE_OFF);
    wire [16:0] acc_tot = smooth ? {1'b0, acc_eff} + {1'b0, scv_eff} : {1'b0, acc_eff};
    wire [16:0] dec_tot = smooth ? {1'b0, dec_eff} + {1'b0, scv_eff} : {1'b0, dec_eff};

    // ------------------------------------------------------------
    // Ramp generator
    // ------------------------------------------------------------
    logic signed [W-1:0] ref_q;
    logic [$clog2(TICK_CYCLES)-1:0] tick_cnt_q;
    wire tick = tick_cnt_q == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1);
    wire signed [W-1:0] cmd_fx = W'(speed_cmd) <<< FRW;
    wire accel = ((cmd_fx > ref_q) && !ref_q[W-1]) || ((cmd_fx < ref_q) && (ref_q <= 0));
    wire [16:0] ramp_time = accel ? acc_tot : dec_tot;
    wire [W-1:0] step = RATED_FX / W'(ramp_time);
    wire signed [W-1:0] diff = cmd_fx - ref_q;
    wire [W-1:0] diff_abs = diff[W-1] ? W'(-diff) : W'(diff);
    wire signed [W-1:0] ref_d = bypass ? cmd_fx :
        (diff_abs <= step) ? cmd_fx :
        diff[W-1] ? ref_q - $signed(step) : ref_q + $signed(step);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tick_cnt_q <= '0;
            ref_q <= '0;
            speed_ref_q <= '0;
        end else if (en) begin
            tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
            if (tick || bypass) ref_q <= ref_d;
            speed_ref_q <= SPW'(ref_q >>> FRW);
        end
    end

    // ------------------------------------------------------------
    // Speed detection outputs
    // ------------------------------------------------------------
    wire [SPW-1:0] meas_abs = speed_meas[SPW-1] ? SPW'(-speed_meas) : SPW'(speed_meas);
    wire [SPW+4:0] target_fx = (SPW+5)'(cfg_q.target) * (SPW+5)'(srzsd_pkg::TARGET_SCALE);
    wire still = meas_abs <= SPW'(cfg_q.window);
    wire reached = (SPW+5)'(meas_abs) >= target_fx;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            standstill_flag_q <= 1'b0;
            speed_reached_flag_q <= 1'b0;
            scurve_en_q <= 1'b0;
            track_comp_q <= 1'b0;
        end else if (en) begin
            standstill_flag_q <= still;
            speed_reached_flag_q <= reached;
            scurve_en_q <= smooth;
            track_comp_q <= comp;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_standstill_set: assert property (@(posedge clk) disable iff (!nrst)
        en && meas_abs <= SPW'(cfg_q.window) |=> standstill_flag_q)
        else $error("standstill flag missing");
    a_standstill_clear: assert property (@(posedge clk) disable iff (!nrst)
        en && meas_abs > SPW'(cfg_q.window) |=> !standstill_flag_q)
        else $error("standstill flag held above window");
    a_reached_flag: assert property (@(posedge clk) disable iff (!nrst)
        en |=> speed_reached_flag_q == $past(reached))
        else $error("speed reached flag wrong");
    a_ramp_step_bound: assert property (@(posedge clk) disable iff (!nrst)
        en && tick && !bypass |=> (ref_q - $past(ref_q) <= $signed($past(step))) &&
        ($past(ref_q) - ref_q <= $signed($past(step))))
        else $error("ramp stepped too far");
    a_analog_bypass: assert property (@(posedge clk) disable iff (!nrst)
        en && bypass ##1 en |=> speed_ref_q == $past(speed_cmd, 2))
        else $error("analog bypass not followed");
    a_accel_clamp: assert property (@(posedge clk) disable iff (!nrst)
        analog_src |-> acc_eff <= srzsd_pkg::ANA_MAX_RAMP)
        else $error("accel not clamped");
    a_decel_clamp: assert property (@(posedge clk) disable iff (!nrst)
        analog_src |-> dec_eff <= srzsd_pkg::ANA_MAX_RAMP)
        else $error("decel not clamped");
    a_scurve_clamp: assert property (@(posedge clk) disable iff (!nrst)
        analog_src |-> scv_eff <= srzsd_pkg::ANA_MAX_SCURVE)
        else $error("scurve not clamped");
    a_scurve_decode: assert property (@(posedge clk) disable iff (!nrst)
        en |=> scurve_en_q == ($past(scv_eff) > srzsd_pkg::SCURVE_COMP_ONLY) &&
        (track_comp_q == ($past(scv_eff) == srzsd_pkg::SCURVE_COMP_ONLY ||
        ($past(scv_eff) > srzsd_pkg::SCURVE_COMP_ONLY && $past(comp_select)))))
        else $error("scurve decode wrong");
    a_total_time: assert property (@(posedge clk) disable iff (!nrst)
        smooth |-> acc_tot == {1'b0, acc_eff} + {1'b0, scv_eff} &&
        dec_tot == {1'b0, dec_eff} + {1'b0, scv_eff})
        else $error("total ramp time wrong");
    a_times_ranged: assert property (@(posedge clk) disable iff (!nrst)
        cfg_q.accel >= srzsd_pkg::MIN_TIME && cfg_q.accel <= srzsd_pkg::MAX_TIME &&
        cfg_q.scurve <= srzsd_pkg::MAX_TIME && cfg_q.inertia <= srzsd_pkg::MAX_INERTIA)
        else $error("setting out of range");
    a_zero_keeps_ramp: assert property (@(posedge clk) disable iff (!nrst)
        !analog_src && scv_eff == srzsd_pkg::SCURVE_OFF |-> !bypass && ramp_time != 17'h0)
        else $error("zero scurve disabled ramp");
    a_plain_ramp_time: assert property (@(posedge clk) disable iff (!nrst)
        !smooth |-> acc_tot == {1'b0, acc_eff} && dec_tot == {1'b0, dec_eff})
        else $error("ramp time changed without smoothing");
    a_decel_window_ranged: assert property (@(posedge clk) disable iff (!nrst)
        cfg_q.decel >= srzsd_pkg::MIN_TIME && cfg_q.decel <= srzsd_pkg::MAX_TIME &&
        cfg_q.window <= srzsd_pkg::MAX_WINDOW)
        else $error("setting out of range");
    a_ramp_exact_step: assert property (@(posedge clk) disable iff (!nrst)
        en && tick && !bypass && diff_abs > step |=>
        (ref_q - $past(ref_q) == $signed($past(step))) ||
        ($past(ref_q) - ref_q == $signed($past(step))))
        else $error("ramp step size wrong");
    a_ramp_up_bound: assert property (@(posedge clk) disable iff (!nrst)
        en && tick && !bypass && cmd_fx > ref_q |=> ref_q > $past(ref_q) && ref_q <= $past(cmd_fx))
        else $error("ramp up overshoot");
    a_ramp_down_bound: assert property (@(posedge clk) disable iff (!nrst)
        en && tick && !bypass && cmd_fx < ref_q |=> ref_q < $past(ref_q) && ref_q >= $past(cmd_fx))
        else $error("ramp down overshoot");
    a_ramp_hold: assert property (@(posedge clk) disable iff (!nrst)
        en && !tick && !bypass |=> $stable(ref_q))
        else $error("reference moved between ticks");
    a_freeze_state: assert property (@(posedge clk) disable iff (!nrst)
        !en |=> $stable(ref_q) && $stable(tick_cnt_q) && $stable(cfg_q))
        else $error("state moved while disabled");
    c_ramp_up: cover property (@(posedge clk) disable iff (!nrst) en && tick && accel);
    c_standstill: cover property (@(posedge clk) disable iff (!nrst) $rose(standstill_flag_q));
    c_reached: cover property (@(posedge clk) disable iff (!nrst) $rose(speed_reached_flag_q));
    c_bypass: cover property (@(posedge clk) disable iff (!nrst) en && bypass);
    c_ramp_down: cover property (@(posedge clk) disable iff (!nrst) en && tick && !accel);
endmodule : srzsd_top

// >>> verif/srzsd_motor_model.sv
// Motor feedback and speed command source model
`timescale 1ns/1ps
module srzsd_motor_model (
    input wire logic signed [23:0] cmd_set,
    input wire logic signed [23:0] meas_set,
    output logic signed [23:0] speed_cmd,
    output logic signed [23:0] speed_meas
);
    // ------------------------------------------------------------
    // Command source and measured speed, both held as levels
    // ------------------------------------------------------------
    assign speed_cmd = cmd_set;
    assign speed_meas = meas_set;
endmodule : srzsd_motor_model

// >>> verif/srzsd_top_test.sv
// Self-checking bench for the speed ramp and standstill block
`timescale 1ns/1ps
module srzsd_top_test;
    logic clk, nrst, en, par_wr, par_rd, analog_src, comp_select;
    logic [15:0] par_addr, par_wdata, par_rdata_q;
    logic signed [23:0] cmd_set, meas_set, speed_cmd, speed_meas, speed_ref_q;
    logic scurve_en_q, track_comp_q, standstill_flag_q, speed_reached_flag_q;
    int fail_count = 0;
    int tests_run = 0;
    srzsd_top #(.TICK_CYCLES(10)) DUT (.clk(clk), .nrst(nrst), .en(en), .par_wr(par_wr),
        .par_rd(par_rd), .par_addr(par_addr), .par_wdata(par_wdata),
        .par_rdata_q(par_rdata_q), .analog_src(analog_src), .comp_select(comp_select),
        .speed_cmd(speed_cmd), .speed_meas(speed_meas), .speed_ref_q(speed_ref_q),
        .scurve_en_q(scurve_en_q), .track_comp_q(track_comp_q),
        .standstill_flag_q(standstill_flag_q),
        .speed_reached_flag_q(speed_reached_flag_q));
    srzsd_motor_model model (.cmd_set(cmd_set), .meas_set(meas_set),
        .speed_cmd(speed_cmd), .speed_meas(speed_meas));
    // ------------------------------------------------------------
    // Clock and shared tasks
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_bit
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask : cyc
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        par_addr = a;
        par_wdata = d;
        par_wr = 1'b1;
        cyc(1);
        par_wr = 1'b0;
        cyc(1);
    endtask : wr
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
        par_addr = a;
        par_rd = 1'b1;
        cyc(1);
        par_rd = 1'b0;
        chk_val({8'h00, par_rdata_q}, {8'h00, exp});
        cyc(1);
    endtask : rd_chk
    task automatic step_chk(input logic signed [23:0] cmd, input logic signed [23:0] exp);
        logic signed [23:0] a;
        cmd_set = cmd;
        cyc(45);
        a = speed_ref_q;
        cyc(10);
        chk_val(speed_ref_q - a, exp);
    endtask : step_chk
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        rd_chk(16'h0144, 16'h00c8);
        rd_chk(16'h0146, 16'h00c8);
        rd_chk(16'h0148, 16'h0000);
        rd_chk(16'h014a, 16'h000a);
        rd_chk(16'h014c, 16'h0064);
        rd_chk(16'h014e, 16'h0bb8);
        rd_chk(16'h0150, 16'h0000);
        wr(16'h0144, 16'hffff);
        rd_chk(16'h0144, 16'hffdc);
        wr(16'h014a, 16'h0bb8);
        rd_chk(16'h014a, 16'h07d0);
        wr(16'h0144, 16'h00c8);
        $display("test registers done");
    endtask : t_regs
    task automatic t_decode;
        for (int v = 0; v < 3; v++) begin
            for (int c = 0; c < 2; c++) begin
                wr(16'h0148, 16'(v));
                comp_select = c[0];
                cyc(2);
                chk_bit(scurve_en_q, v > 1);
                chk_bit(track_comp_q, (v == 1) || (v > 1 && c == 1));
            end
        end
        $display("test smoothing decode done");
    endtask : t_decode
    task automatic t_ramp;
        wr(16'h0148, 16'h0000);
        step_chk(24'sd30000, 24'sd150);
        cyc(100);
        wr(16'h0148, 16'h0064);
        step_chk(24'sd30000, 24'sd100);
        step_chk(24'sd0, -24'sd100);
        wr(16'h0148, 16'h0000);
        step_chk(24'sd0, -24'sd150);
        $display("test ramp done");
    endtask : t_ramp
    task automatic t_analog;
        analog_src = 1'b1;
        cmd_set = 24'sd12345;
        cyc(3);
        chk_val(speed_ref_q, 24'sd12345);
        wr(16'h0144, 16'hea60);
        wr(16'h0146, 16'hea60);
        wr(16'h0148, 16'h7530);
        step_chk(24'sd30000, 24'sd1);
        step_chk(24'sd0, -24'sd1);
        analog_src = 1'b0;
        $display("test analog source done");
    endtask : t_analog
    task automatic t_flags;
        logic signed [23:0] sp [6] = '{100, 101, -100, 29999, 30000, -30000};
        logic ss [6] = '{1, 0, 1, 0, 0, 0};
        logic rs [6] = '{0, 0, 0, 0, 1, 1};
        for (int i = 0; i < 6; i++) begin
            meas_set = sp[i];
            cyc(2);
            chk_bit(standstill_flag_q, ss[i]);
            chk_bit(speed_reached_flag_q, rs[i]);
        end
        $display("test speed flags done");
    endtask : t_flags
    task automatic t_freeze;
        logic signed [23:0] a;
        a = speed_ref_q;
        en = 1'b0;
        cmd_set = -24'sd30000;
        wr(16'h014c, 16'h0032);
        cyc(30);
        chk_val(speed_ref_q, a);
        en = 1'b1;
        rd_chk(16'h014c, 16'h0064);
        wr(16'h014c, 16'h0032);
        meas_set = 24'sd51;
        cyc(2);
        chk_bit(standstill_flag_q, 1'b0);
        $display("test clock enable done");
    endtask : t_freeze
    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results
    initial begin
        {nrst, par_wr, par_rd, analog_src, comp_select} = 5'h00;
        en = 1'b1;
        par_addr = 16'h0000;
        par_wdata = 16'h0000;
        cmd_set = 24'sd0;
        meas_set = 24'sd0;
        cyc(20);
        nrst = 1'b1;
        t_regs();
        t_decode();
        t_ramp();
        t_analog();
        t_flags();
        t_freeze();
        results();
    end
    initial begin
        #2_000_000;
        fail_count++;
        results();
    end
endmodule : srzsd_top_test
